//--- cwl_pkg.sv
/*
  constants, types and the register map of the configuration word loader.
  assumes: one 100 MHz clock domain; flash answers a read while it stands.
*/
`default_nettype none

package cwl_pkg;

  // bus and word widths
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_CFG = 4;
  localparam int unsigned IDX_W = 2;

  // configuration word registers, at their boot flash byte addresses
  localparam logic [31:0] OFS_CFG3 = 32'h1fc0_2ff0;
  localparam logic [31:0] OFS_CFG2 = 32'h1fc0_2ff4;
  localparam logic [31:0] OFS_CFG1 = 32'h1fc0_2ff8;
  localparam logic [31:0] OFS_CFG0 = 32'h1fc0_2ffc;
  // loader control and status registers
  localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFS_PROG_DATA = 32'h0000_0004;
  localparam logic [31:0] OFS_FLASH_SUM = 32'h0000_0008;
  localparam logic [31:0] OFS_STATUS = 32'h0000_000c;
  localparam logic [31:0] OFS_CHECKSUM = 32'h0000_0010;

  // reset values: erased flash reads as all ones, word 0 top bit clear
  localparam logic [31:0] RST_CFG0 = 32'h7fff_ffff;
  localparam logic [31:0] RST_CFG123 = 32'hffff_ffff;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // boot flash layouts: address of word 0, words step down by four bytes
  localparam logic [31:0] STD_TOP = 32'h1fc0_2ffc;
  localparam logic [31:0] SMALL_TOP = 32'h1fc0_0bfc;
  localparam logic [31:0] DUAL_TOP = 32'h1fc4_ffcc;
  localparam logic [31:0] ALT_OFFSET = 32'h0000_0080;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;

  // field positions
  localparam int unsigned CTRL_IDX_LSB = 0;
  localparam int unsigned CTRL_GO_BIT = 8;
  localparam int unsigned CP_BIT = 28;
  localparam int unsigned OSC_LSB = 0;
  localparam int unsigned OSC_W = 3;
  localparam logic [2:0] INT_RC_CODE = 3'h0;
  localparam int unsigned ST_DONE_BIT = 0;
  localparam int unsigned ST_BUSY_BIT = 1;
  localparam int unsigned ST_CP_BIT = 2;
  localparam int unsigned ST_OSC_OK_BIT = 3;
  localparam int unsigned ST_REFUSED_BIT = 4;

  // timing: load of four words ends within this many cycles of release
  localparam int unsigned LOAD_CYCLES = 12;

  // placement of the configuration words in boot flash
  typedef enum logic [1:0] {LAYOUT_STD, LAYOUT_SMALL, LAYOUT_DUAL} cwl_layout_e;

  // loader sequence
  typedef enum logic [2:0] {
    ST_LOAD_REQ, ST_LOAD_CAP, ST_IDLE, ST_PROG_REQ, ST_PROG_CAP, ST_PROG_WR
  } cwl_state_e;

  // one request towards the boot flash
  typedef struct packed {
    logic rd;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cwl_flash_req_s;

endpackage : cwl_pkg

`default_nettype wire

//--- cwl_loader.sv
/*
  configuration word loader: copies the four configuration words out of
  boot flash after every reset, serves them read only, programs words
  with one-way bit clearing, gates the oscillator choice and reports the
  masked checksum.
  assumes: flash read data is valid while the registered rd stands; register port
  strobes are one cycle long and never overlap.
*/
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - erased flash bytes read as all ones
// - code protected device reports zero checksum
// - every reset reloads config words from flash
// - config bits only go one to zero
// - new config values wait for next reset
// - two wire mode forces internal RC oscillator
// - absent oscillator blocks programming, not the reset load
// - words at top of boot flash, step four
// - small variant places words lower
// - dual boot copy with alternate 0x80 lower
module cwl_loader #(
  parameter cwl_pkg::cwl_layout_e LAYOUT = cwl_pkg::LAYOUT_STD,
  parameter logic [31:0] MASK_CFG0 = 32'h110f_f00b,
  parameter logic [31:0] MASK_CFG1 = 32'h009f_f7a7,
  parameter logic [31:0] MASK_CFG2 = 32'h0007_0077,
  parameter logic [31:0] MASK_CFG3 = 32'h0000_0000,
  parameter logic [31:0] MASK_ID = 32'h000f_f000,
  // identifier value is arbitrary
  parameter logic [31:0] ID_WORD = 32'h0012_3456
) (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic [31:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output cwl_pkg::cwl_flash_req_s FLASH_REQ,
  input wire logic [31:0] FLASH_RDATA,
  input wire logic TWO_WIRE_MODE,
  input wire logic ALT_COPY,
  input wire logic [7:0] OSC_PRESENT,
  output logic [2:0] OSC_SEL,
  output logic CODE_PROTECT,
  output logic LOAD_DONE
);

  ////////////////////////////////////////////////////////////////////////
  // state and storage

  cwl_pkg::cwl_state_e state_r, state_nxt; // loader sequence
  logic [31:0] cfg_r [cwl_pkg::NUM_CFG]; // loaded configuration words
  logic [1:0] idx_r, idx_nxt; // word being loaded or programmed
  logic load_done_r, load_done_nxt; // all four words loaded
  logic [31:0] prog_data_r; // new value asked for by software
  logic [31:0] old_word_r; // word read back before programming
  logic [31:0] flash_sum_r; // main plus boot flash byte sums
  logic refused_r; // set when a program request is refused (no oscillator or busy), cleared by an accepted one
  logic [31:0] checksum_r; // reported checksum
  logic [31:0] rdata_r; // read data register
  cwl_pkg::cwl_flash_req_s req_r, req_nxt; // flash request register
  logic [2:0] osc_r; // effective oscillator
  logic cp_r; // code protection active

  ////////////////////////////////////////////////////////////////////////
  // address decode and register strobes

  wire hit_ctrl = (REG_ADDR == cwl_pkg::OFS_CTRL);
  wire hit_prog = (REG_ADDR == cwl_pkg::OFS_PROG_DATA);
  wire hit_sum = (REG_ADDR == cwl_pkg::OFS_FLASH_SUM);
  wire hit_stat = (REG_ADDR == cwl_pkg::OFS_STATUS);
  wire hit_csum = (REG_ADDR == cwl_pkg::OFS_CHECKSUM);
  wire hit_cfg0 = (REG_ADDR == cwl_pkg::OFS_CFG0);
  wire hit_cfg1 = (REG_ADDR == cwl_pkg::OFS_CFG1);
  wire hit_cfg2 = (REG_ADDR == cwl_pkg::OFS_CFG2);
  wire hit_cfg3 = (REG_ADDR == cwl_pkg::OFS_CFG3);
  wire go_wr = REG_WR && hit_ctrl && REG_WDATA[cwl_pkg::CTRL_GO_BIT];
  wire [1:0] go_idx = REG_WDATA[cwl_pkg::CTRL_IDX_LSB +: cwl_pkg::IDX_W];

  ////////////////////////////////////////////////////////////////////////
  // flash word addresses

  // top of the chosen layout, alternate copy sits lower on dual parts
  wire [31:0] top_std = (LAYOUT == cwl_pkg::LAYOUT_SMALL) ?
    cwl_pkg::SMALL_TOP : cwl_pkg::STD_TOP;
  wire [31:0] top_dual = ALT_COPY ?
    (cwl_pkg::DUAL_TOP - cwl_pkg::ALT_OFFSET) : cwl_pkg::DUAL_TOP;
  wire [31:0] top_addr = (LAYOUT == cwl_pkg::LAYOUT_DUAL) ? top_dual : top_std;
  // word 0 at the top, word 3 lowest
  wire [31:0] idx_ofs = {30'h0, idx_nxt} * cwl_pkg::WORD_STEP;
  wire [31:0] word_addr = top_addr - idx_ofs;

  ////////////////////////////////////////////////////////////////////////
  // oscillator choice and flash access permission

  wire [2:0] osc_field = cfg_r[1][cwl_pkg::OSC_LSB +: cwl_pkg::OSC_W];
  wire [2:0] osc_eff = TWO_WIRE_MODE ? cwl_pkg::INT_RC_CODE : osc_field;
  wire osc_ok = OSC_PRESENT[osc_eff];
  // code protection bit is active when programmed to zero
  wire cp_now = load_done_r && !cfg_r[0][cwl_pkg::CP_BIT];

  ////////////////////////////////////////////////////////////////////////
  // masked byte sums

  // zero extended sum of the four bytes of a word
  function automatic logic [31:0] byte_sum(input logic [31:0] w);
    byte_sum = {24'h0, w[7:0]} + {24'h0, w[15:8]} + {24'h0, w[23:16]}
      + {24'h0, w[31:24]};
  endfunction : byte_sum

  wire [31:0] mask_cfg [cwl_pkg::NUM_CFG];
  assign mask_cfg[0] = MASK_CFG0;
  assign mask_cfg[1] = MASK_CFG1;
  assign mask_cfg[2] = MASK_CFG2;
  assign mask_cfg[3] = MASK_CFG3;
  wire [31:0] part_sum [cwl_pkg::NUM_CFG];

  // one masked byte sum per configuration word
  genvar g;
  generate
    for (g = 0; g < cwl_pkg::NUM_CFG; g = g + 1) begin : g_sum
      assign part_sum[g] = byte_sum(cfg_r[g] & mask_cfg[g]);
    end
  endgenerate

  wire [31:0] cfg_sum = part_sum[0] + part_sum[1] + part_sum[2] + part_sum[3];
  wire [31:0] id_sum = byte_sum(ID_WORD & MASK_ID);
  // wraps at 32 bits, then two's complement
  wire [31:0] total = flash_sum_r + cfg_sum + id_sum;
  wire [31:0] checksum_nxt = cp_now ? cwl_pkg::ZERO_WORD : (~total + 32'h0000_0001);

  ////////////////////////////////////////////////////////////////////////
  // read data selection

  wire [31:0] status_word = {27'h0, refused_r, osc_ok, cp_r,
    (state_r != cwl_pkg::ST_IDLE), load_done_r};
  wire [31:0] rd_sel =
    hit_cfg0 ? cfg_r[0] :
    hit_cfg1 ? cfg_r[1] :
    hit_cfg2 ? cfg_r[2] :
    hit_cfg3 ? cfg_r[3] :
    hit_ctrl ? {30'h0, idx_r} :
    hit_prog ? prog_data_r :
    hit_sum ? flash_sum_r :
    hit_stat ? status_word :
    hit_csum ? checksum_r : cwl_pkg::ZERO_WORD;

  ////////////////////////////////////////////////////////////////////////
  // sequence: next state and flash request

  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    load_done_nxt = load_done_r;
    req_nxt = '0;
    case (state_r)
      // issue a read of the current configuration word
      cwl_pkg::ST_LOAD_REQ: begin
        req_nxt.rd = 1'b1;
        state_nxt = cwl_pkg::ST_LOAD_CAP;
      end
      // data captured this cycle; move on or finish
      cwl_pkg::ST_LOAD_CAP: begin
        if (idx_r == 2'h3) begin
          load_done_nxt = 1'b1;
          state_nxt = cwl_pkg::ST_IDLE;
        end else begin
          idx_nxt = idx_r + 2'h1;
          state_nxt = cwl_pkg::ST_LOAD_REQ;
        end
      end
      // wait for a program request with a usable oscillator
      cwl_pkg::ST_IDLE: begin
        if (go_wr && osc_ok) begin
          idx_nxt = go_idx;
          state_nxt = cwl_pkg::ST_PROG_REQ;
        end
      end
      // read back the word about to be programmed
      cwl_pkg::ST_PROG_REQ: begin
        req_nxt.rd = 1'b1;
        state_nxt = cwl_pkg::ST_PROG_CAP;
      end
      cwl_pkg::ST_PROG_CAP: begin
        state_nxt = cwl_pkg::ST_PROG_WR;
      end
      // write: bits may only clear, never set
      cwl_pkg::ST_PROG_WR: begin
        req_nxt.wr = osc_ok;
        req_nxt.wdata = old_word_r & prog_data_r;
        state_nxt = cwl_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = cwl_pkg::ST_IDLE;
      end
    endcase
    req_nxt.addr = (req_nxt.rd || req_nxt.wr) ? word_addr : cwl_pkg::ZERO_WORD;
  end

  ////////////////////////////////////////////////////////////////////////
  // sequence registers: every reset restarts the load at word 0

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= cwl_pkg::ST_LOAD_REQ;
      idx_r <= 2'h0;
      load_done_r <= 1'b0;
      req_r <= '0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      load_done_r <= load_done_nxt;
      req_r <= req_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration words: only the reset load writes them

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg_r[0] <= cwl_pkg::RST_CFG0;
      cfg_r[1] <= cwl_pkg::RST_CFG123;
      cfg_r[2] <= cwl_pkg::RST_CFG123;
      cfg_r[3] <= cwl_pkg::RST_CFG123;
    end else if (state_r == cwl_pkg::ST_LOAD_CAP) begin
      cfg_r[idx_r] <= FLASH_RDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers and read back

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      prog_data_r <= cwl_pkg::RST_CFG123;
      flash_sum_r <= cwl_pkg::ZERO_WORD;
      old_word_r <= cwl_pkg::RST_CFG123;
      rdata_r <= cwl_pkg::ZERO_WORD;
    end else begin
      if (REG_WR && hit_prog) begin
        prog_data_r <= REG_WDATA;
      end
      if (REG_WR && hit_sum) begin
        flash_sum_r <= REG_WDATA;
      end
      if (state_r == cwl_pkg::ST_PROG_CAP) begin
        old_word_r <= FLASH_RDATA;
      end
      // read data stands only in the cycle after the strobe
      rdata_r <= REG_RD ? rd_sel : cwl_pkg::ZERO_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // refusal flag, set wins over clear

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      refused_r <= 1'b0;
    end else if (go_wr && (!osc_ok || state_r != cwl_pkg::ST_IDLE)) begin
      refused_r <= 1'b1;
    end else if (go_wr) begin
      refused_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      checksum_r <= cwl_pkg::ZERO_WORD;
      osc_r <= cwl_pkg::INT_RC_CODE;
      cp_r <= 1'b0;
    end else begin
      checksum_r <= checksum_nxt;
      osc_r <= osc_eff;
      cp_r <= cp_now;
    end
  end

  assign REG_RDATA = rdata_r;
  assign FLASH_REQ = req_r;
  assign OSC_SEL = osc_r;
  assign CODE_PROTECT = cp_r;
  assign LOAD_DONE = load_done_r;

  ////////////////////////////////////////////////////////////////////////
  // checks

  // cycles since reset release, saturating
  logic [4:0] since_rst_r;
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      since_rst_r <= 5'h00;
    end else if (since_rst_r != 5'h1f) begin
      since_rst_r <= since_rst_r + 5'h01;
    end
  end

  sequence s_load_cap;
    state_r == cwl_pkg::ST_LOAD_CAP;
  endsequence

  sequence s_prog_wr;
    state_r == cwl_pkg::ST_PROG_WR ##1 FLASH_REQ.wr;
  endsequence

  a_load_bound: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (since_rst_r >= 5'(cwl_pkg::LOAD_CYCLES)) |-> LOAD_DONE)
    else $error("config load not finished in time");

  a_load_capture: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    s_load_cap |=> (cfg_r[$past(idx_r)] == $past(FLASH_RDATA)))
    else $error("config word not captured from flash");

  a_erased_default: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (since_rst_r == 5'h00) |-> (cfg_r[0] == cwl_pkg::RST_CFG0
      && cfg_r[3] == cwl_pkg::RST_CFG123))
    else $error("config words not erased value after reset");

  a_cp_zero_sum: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    cp_now |=> (REG_RDATA == 32'h0000_0000 || !$past(REG_RD && hit_csum))
      && checksum_r == 32'h0000_0000)
    else $error("protected device reports nonzero checksum");

  a_one_way_bits: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    s_prog_wr |-> ((FLASH_REQ.wdata | $past(old_word_r)) == $past(old_word_r)))
    else $error("programming would set a config bit");

  a_no_live_update: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (load_done_r && $past(load_done_r)) |-> $stable(cfg_r[0]) && $stable(cfg_r[1]))
    else $error("config register changed without reset");

  a_two_wire_rc: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    TWO_WIRE_MODE |=> (OSC_SEL == cwl_pkg::INT_RC_CODE))
    else $error("two wire mode did not select internal oscillator");

  a_osc_blocks: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (go_wr && !osc_ok && state_r == cwl_pkg::ST_IDLE) |=> !FLASH_REQ.rd [*3])
    else $error("flash access started with absent oscillator");

  a_word_address: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (FLASH_REQ.rd && !LOAD_DONE) |-> (FLASH_REQ.addr == top_addr
      - ({30'h0, idx_r} * cwl_pkg::WORD_STEP)))
    else $error("config word read at wrong address");

endmodule : cwl_loader

`default_nettype wire

//--- cwl_flash_model.sv
/*
  boot flash model facing the configuration word loader.
  assumes: requests are registered pulses; a read is answered while the
  registered request stands, and the data line wanders at all other times.
*/
`timescale 1ns/100ps
`default_nettype none

module cwl_flash_model (
  input wire logic clk,
  input wire cwl_pkg::cwl_flash_req_s req,
  output logic [31:0] rdata
);
  // stored words by byte address; a missing entry is an erased word
  logic [31:0] mem [logic [31:0]];
  // pattern shown on the data line while no read stands
  logic [31:0] noise_r;

  // erased words read back as all ones
  function automatic logic [31:0] fetch(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 32'hffff_ffff;
  endfunction : fetch

  initial noise_r = 32'h0000_0000;

  //////////////////////////////////////////////////////////////////////
  // read answer while the registered request stands, otherwise noise
  assign rdata = req.rd ? fetch(req.addr) : noise_r;

  // noise keeps changing; programming can only clear bits, never set them
  always @(posedge clk) begin
    noise_r <= ~noise_r;
    if (req.wr) begin
      mem[req.addr] = fetch(req.addr) & req.wdata;
    end
  end
endmodule : cwl_flash_model

`default_nettype wire

//--- config_word_load_checksum_tb_top.sv
/*
  self-checking bench for the configuration word loader.
  assumes: cwl_pkg, cwl_loader and cwl_flash_model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module config_word_load_checksum_tb_top;
  // masks and identifier handed to the loader; identifier value arbitrary
  localparam logic [31:0] M0 = 32'h110f_f00b;
  localparam logic [31:0] M1 = 32'h009f_f7a7;
  localparam logic [31:0] M2 = 32'h0007_0077;
  localparam logic [31:0] M3 = 32'h0000_0000;
  localparam logic [31:0] MID = 32'h000f_f000;
  localparam logic [31:0] IDW = 32'h0012_3456;
  logic ref_clk, reset_n, reg_wr, reg_rd, two_wire, load_done, code_protect, alt_copy;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, flash_rdata, wr_addr, wr_data, v;
  logic [7:0] osc_present;
  logic [2:0] osc_sel;
  cwl_pkg::cwl_flash_req_s flash_req, dual_req, small_req;
  logic [31:0] rd_addrs[$], dual_addrs[$], small_addrs[$];
  int num_errors = 0, comparisons = 0, wr_count = 0;

  cwl_loader #(.MASK_CFG0(M0), .MASK_CFG1(M1), .MASK_CFG2(M2), .MASK_CFG3(M3),
    .MASK_ID(MID), .ID_WORD(IDW)) uut (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .FLASH_REQ(flash_req),
    .FLASH_RDATA(flash_rdata), .TWO_WIRE_MODE(two_wire), .ALT_COPY(1'b0),
    .OSC_PRESENT(osc_present), .OSC_SEL(osc_sel), .CODE_PROTECT(code_protect),
    .LOAD_DONE(load_done));
  // dual boot layout, reading the alternate copy while alt_copy is set
  cwl_loader #(.LAYOUT(cwl_pkg::LAYOUT_DUAL)) uut_dual (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(1'b0), .REG_RD(1'b0), .REG_RDATA(), .FLASH_REQ(dual_req),
    .FLASH_RDATA(flash_rdata), .TWO_WIRE_MODE(two_wire), .ALT_COPY(alt_copy),
    .OSC_PRESENT(osc_present), .OSC_SEL(), .CODE_PROTECT(), .LOAD_DONE());
  // small boot flash layout
  cwl_loader #(.LAYOUT(cwl_pkg::LAYOUT_SMALL)) uut_small (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(1'b0), .REG_RD(1'b0), .REG_RDATA(), .FLASH_REQ(small_req),
    .FLASH_RDATA(flash_rdata), .TWO_WIRE_MODE(two_wire), .ALT_COPY(1'b0),
    .OSC_PRESENT(osc_present), .OSC_SEL(), .CODE_PROTECT(), .LOAD_DONE());
  cwl_flash_model flash (.clk(ref_clk), .req(flash_req), .rdata(flash_rdata));

  always #5 ref_clk = ~ref_clk;

  //////////////////////////////////////////////////////////////////////
  // log flash traffic as the loaders drive it
  always @(posedge ref_clk) begin
    if (flash_req.rd) rd_addrs.push_back(flash_req.addr);
    if (dual_req.rd) dual_addrs.push_back(dual_req.addr);
    if (small_req.rd) small_addrs.push_back(small_req.addr);
    if (flash_req.wr) begin
      wr_count++;
      wr_addr = flash_req.addr;
      wr_data = flash_req.wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr_reg

  // read data stands only in the cycle after the read edge
  task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd_reg

  function automatic logic [31:0] bsum(input logic [31:0] w);
    return 32'(w[31:24]) + 32'(w[23:16]) + 32'(w[15:8]) + 32'(w[7:0]);
  endfunction : bsum

  // invert plus one over the wrapping total
  function automatic logic [31:0] exp_sum(input logic [31:0] c[4], input logic [31:0] fs);
    return ~(fs + bsum(c[0] & M0) + bsum(c[1] & M1) + bsum(c[2] & M2)
      + bsum(c[3] & M3) + bsum(IDW & MID)) + 32'h0000_0001;
  endfunction : exp_sum

  // reset, then follow the load of the four words
  task automatic do_reset;
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 check(32'(load_done), 32'h0);
    rd_addrs.delete();
    dual_addrs.delete();
    small_addrs.delete();
    @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 20 && load_done !== 1'b1; i++) @(posedge ref_clk);
    #1 check(32'(rd_addrs.size()), 32'h4);
    for (int i = 0; i < 4 && i < rd_addrs.size(); i++)
      check(rd_addrs[i], cwl_pkg::STD_TOP - 32'(4 * i));
    check(dual_addrs[0], alt_copy ? 32'h1fc4_ff4c : 32'h1fc4_ffcc);
    check(dual_addrs[3], alt_copy ? 32'h1fc4_ff40 : 32'h1fc4_ffc0);
    check(small_addrs[0], 32'h1fc0_0bfc);
    check(small_addrs[3], 32'h1fc0_0bf0);
  endtask : do_reset

  task automatic prog(input logic [31:0] idx, input logic [31:0] d);
    int n;
    n = wr_count;
    wr_reg(cwl_pkg::OFS_PROG_DATA, d);
    wr_reg(cwl_pkg::OFS_CTRL, 32'h0000_0100 | idx);
    for (int i = 0; i < 20 && wr_count == n; i++) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
  endtask : prog

  //////////////////////////////////////////////////////////////////////
  // erased flash loads all ones and gives the erased checksum
  task automatic t_erased;
    logic [31:0] c[4] = '{4{32'hffff_ffff}};
    flash.mem.delete();
    do_reset();
    for (int i = 0; i < 4; i++) begin
      rd_reg(cwl_pkg::OFS_CFG0 - 32'(4 * i), v);
      check(v, 32'hffff_ffff);
    end
    wr_reg(cwl_pkg::OFS_FLASH_SUM, 32'h07f8_0000 + 32'h002f_c010);
    rd_reg(cwl_pkg::OFS_CHECKSUM, v);
    check(v, exp_sum(c, 32'h0827_c010));
  endtask : t_erased

  // programmed words, wrapping sum, oscillator choice, read only words
  task automatic t_loaded;
    logic [31:0] c[4] = '{32'h7fff_fff0, 32'hffff_fffd, 32'h1234_5678, 32'hffff_0000};
    for (int i = 0; i < 4; i++) flash.mem[cwl_pkg::STD_TOP - 32'(4 * i)] = c[i];
    do_reset();
    for (int i = 0; i < 4; i++) begin
      rd_reg(cwl_pkg::OFS_CFG0 - 32'(4 * i), v);
      check(v, c[i]);
    end
    wr_reg(cwl_pkg::OFS_FLASH_SUM, 32'hffff_ff00);
    rd_reg(cwl_pkg::OFS_CHECKSUM, v);
    check(v, exp_sum(c, 32'hffff_ff00));
    repeat (3) @(posedge ref_clk);
    #1 check(32'(osc_sel), 32'h5);
    @(posedge ref_clk);
    two_wire <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 check(32'(osc_sel), 32'(cwl_pkg::INT_RC_CODE));
    @(posedge ref_clk);
    two_wire <= 1'b0;
    wr_reg(cwl_pkg::OFS_CFG2, 32'h0000_0000);
    rd_reg(cwl_pkg::OFS_CFG2, v);
    check(v, c[2]);
    rd_reg(32'h0000_0100, v);
    check(v, 32'h0000_0000);
  endtask : t_loaded

  // absent oscillator blocks programming
  task automatic t_refuse;
    int n;
    n = wr_count;
    @(posedge ref_clk);
    osc_present <= 8'hdf;
    repeat (3) @(posedge ref_clk);
    prog(32'h1, 32'h0000_0000);
    check(32'(wr_count - n), 32'h0);
    rd_reg(cwl_pkg::OFS_STATUS, v);
    check(32'(v[cwl_pkg::ST_REFUSED_BIT]), 32'h1);
    check(32'(v[cwl_pkg::ST_OSC_OK_BIT]), 32'h0);
    @(posedge ref_clk);
    osc_present <= 8'hff;
  endtask : t_refuse

  // words 2 and 0 programmed once, protection last, seen only after reset
  task automatic t_program;
    prog(32'h2, 32'h0000_ffff);
    check(wr_addr, cwl_pkg::OFS_CFG2);
    check(wr_data, 32'h0000_5678);
    rd_reg(cwl_pkg::OFS_STATUS, v);
    check(32'(v[cwl_pkg::ST_REFUSED_BIT]), 32'h0);
    rd_reg(cwl_pkg::OFS_CFG2, v);
    check(v, 32'h1234_5678);
    prog(32'h0, 32'hefff_ffff);
    check(32'(code_protect), 32'h0);
    // third reset reads the base copy on the dual layout
    alt_copy <= 1'b0;
    do_reset();
    rd_reg(cwl_pkg::OFS_CFG2, v);
    check(v, 32'h0000_5678);
    check(32'(code_protect), 32'h1);
    rd_reg(cwl_pkg::OFS_CHECKSUM, v);
    check(v, 32'h0000_0000);
  endtask : t_program

  //////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    reg_addr = 32'h0000_0000;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    two_wire = 1'b0;
    alt_copy = 1'b1;
    osc_present = 8'hff;
    t_erased();
    t_loaded();
    t_refuse();
    t_program();
    stop_test();
  end

  // watchdog far beyond the 150 or so cycles the tests take
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
endmodule : config_word_load_checksum_tb_top

`default_nettype wire
